//--- src/iex_alu.sv
/*
  result and status logic for the immediate arithmetic and logic group.
  assumes operands come from registers of the caller; purely combinational.
*/
`timescale 1ns/1ns
module iex_alu (
  input  iex_pkg::iex_op_t op,
  input  wire logic [15:0] reg_val,
  input  wire logic [15:0] imm,
  input  wire logic [15:0] stat_in,
  output logic [15:0]      res,
  output logic [15:0]      stat_out
);
  import iex_pkg::*;
  logic [16:0] sum;

  // sum with carry out for the add form
  assign sum = {1'b0, reg_val} + {1'b0, imm};

  // result and the status bits each form touches
  always_comb begin
    res = imm;
    stat_out = stat_in;
    case (op)
      add_immediate_op: res = sum[15:0];
      and_immediate_op: res = reg_val & imm;
      or_immediate_op:  res = reg_val | imm;
      default:          res = imm;
    endcase
    if (op == compare_immediate_op) begin
      stat_out[STAT_LGT] = reg_val > imm;
      stat_out[STAT_AGT] = $signed(reg_val) > $signed(imm);
      stat_out[STAT_EQ]  = reg_val == imm;
    end else begin
      stat_out[STAT_LGT] = res != 16'h0000;
      stat_out[STAT_AGT] = !res[15] && (res != 16'h0000);
      stat_out[STAT_EQ]  = res == 16'h0000;
    end
    if (op == add_immediate_op) begin
      stat_out[STAT_C]  = sum[16];
      stat_out[STAT_OV] = (reg_val[15] == imm[15]) && (res[15] != reg_val[15]);
    end
  end
endmodule

//--- src/iex_exec.sv
/*
  execution unit for the immediate group, the extended-operation trap and
  the workspace return; ahb-lite slave for control, word master to memory.
  assumes memory answers each request with a one-cycle mem_ack pulse.
*/
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
// How it works
// - immediate group except the two stores reads operand after instruction; load copies it, sets status 0-2.
// - add immediate writes register plus operand, status 0-4 from result.
// - and/or immediate write bitwise result back, status 0-2 from result.
// - compare immediate sets status 0-2 and never writes the register.
// - load workspace pointer takes operand into pointer, status untouched.
// - load interrupt mask copies operand bits 12-15 to status bits 12-15.
// - store status writes whole status to register; stores change no status.
// - store workspace pointer writes pointer value into register.
// - trap sets status bit 6 during the context switch.
// - trap D reads pointer at 0x40+4D and counter at 0x42+4D.
// - vector table spans 0x40 to 0x7e, traps 0 to 15.
// - trap saves old pointer, counter, status into new registers 13-15.
// - trap writes source operand address into new register 11.
// - trap source uses mode and register fields, all four modes.
// - after trap maskable request is not sampled; reset and load still are.
// - return restores counter, pointer, status from registers 14, 13, 15.
`timescale 1ns/1ns
module iex_exec (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             mem_req,
  output iex_pkg::iex_mem_t mem_out,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        reset_request,
  input  wire logic        load_request,
  input  wire logic        maskable_int_request,
  output logic             busy,
  output logic             reset_take,
  output logic             load_take,
  output logic             int_take
);
  import iex_pkg::*;

  iex_state_t  fsm_q;
  iex_op_t     op_q;
  iex_mem_t    mem_q, acc;
  logic [15:0] ir_q, pc_q, wp_q, status_q, imm_q, dat_q, wr_q, sa_q, nwp_q, npc_q;
  logic [2:0]  s1_q, s2_q;
  logic        req_q, busy_q, bad_q, rtk_q, ltk_q, itk_q;
  logic        ap_wr_q, ap_sel_q;
  logic [7:0]  ap_addr_q;
  logic [31:0] hrdata_q;

  // ahb address phase decode
  wire         ap_valid = hsel && hready && htrans[1];
  wire [7:0]   ap_addr  = haddr[7:0];
  wire         dp_wr    = ap_sel_q && ap_wr_q;
  wire         start    = dp_wr && (ap_addr_q == REG_INSTR) && !busy_q;
  wire         idle_wr  = dp_wr && !busy_q;

  // instruction decode
  wire [3:0]   rn       = ir_q[3:0];
  wire [1:0]   smode    = ir_q[5:4];
  wire [3:0]   tnum     = ir_q[9:6];
  wire [15:0]  reg_addr = wp_q + {11'h000, rn, 1'b0};
  wire [15:0]  vec_addr = VEC_BASE + {10'h000, tnum, 2'b00};
  wire [15:0]  hw       = hwdata[15:0];
  wire [10:0]  opc      = hw[15:5];
  wire         is_trap  = hw[15:10] == TRAP_PAT;
  wire         is_imm   = (opc >= OPC_LOADI) && (opc <= OPC_LOADI + 11'h008);
  wire [3:0]   imm_idx  = 4'(opc - OPC_LOADI);
  wire iex_op_t dec_op  = is_trap ? extended_operation_trap :
                          (opc == OPC_RET) ? workspace_return_op :
                          is_imm ? iex_op_t'(imm_idx) : bad_op;
  wire [15:0]  alu_res, alu_stat;
  wire         acc_st   = (fsm_q != S_IDLE) && (fsm_q != S_EXE) && (fsm_q != S_END);
  wire         done     = req_q && mem_ack;

  iex_alu u_alu (
    .op       (op_q),
    .reg_val  (dat_q),
    .imm      (imm_q),
    .stat_in  (status_q),
    .res      (alu_res),
    .stat_out (alu_stat)
  );

  // memory request for each access state
  always_comb begin
    acc = '{we: 1'b0, addr: reg_addr, wdata: wr_q};
    case (fsm_q)
      S_IMM:   acc.addr = pc_q;
      S_SIDX:  acc.addr = pc_q;
      S_WREG:  acc.we = 1'b1;
      S_SINC:  acc = '{we: 1'b1, addr: reg_addr, wdata: sa_q + WORD_INC};
      S_VWP:   acc.addr = vec_addr;
      S_VPC:   acc.addr = vec_addr + VEC_PCOFS;
      S_S11:   acc = '{we: 1'b1, addr: nwp_q + OFS_R11, wdata: sa_q};
      S_S13:   acc = '{we: 1'b1, addr: nwp_q + OFS_R13, wdata: wp_q};
      S_S14:   acc = '{we: 1'b1, addr: nwp_q + OFS_R14, wdata: pc_q};
      S_S15:   acc = '{we: 1'b1, addr: nwp_q + OFS_R15, wdata: status_q};
      S_R14:   acc.addr = wp_q + OFS_R14;
      S_R13:   acc.addr = wp_q + OFS_R13;
      S_R15:   acc.addr = wp_q + OFS_R15;
      default: acc.addr = reg_addr;
    endcase
  end

  // request pins pass two flops before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      s1_q <= {reset_request, load_request, maskable_int_request};
      s2_q <= s1_q;
    end
  end

  // ahb slave: zero wait states, read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_sel_q  <= 1'b0;
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
    end else begin
      ap_sel_q  <= ap_valid;
      ap_wr_q   <= hwrite;
      ap_addr_q <= ap_addr;
      if (ap_valid && !hwrite) begin
        case (ap_addr)
          REG_INSTR: hrdata_q <= {16'h0000, ir_q};
          REG_PC:    hrdata_q <= {16'h0000, pc_q};
          REG_WP:    hrdata_q <= {16'h0000, wp_q};
          REG_STAT:  hrdata_q <= {16'h0000, status_q};
          REG_INFO:  hrdata_q <= {27'h0000000, itk_q, ltk_q, rtk_q, bad_q, busy_q};
          default:   hrdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // sequencer: one memory word per access state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fsm_q <= S_IDLE;
      op_q <= bad_op;
      mem_q <= '0;
      {ir_q, imm_q, dat_q, wr_q, sa_q, nwp_q, npc_q} <= '0;
      pc_q <= RST_PC;
      wp_q <= RST_WP;
      status_q <= RST_STAT;
      {req_q, busy_q, bad_q, rtk_q, ltk_q, itk_q} <= 6'h00;
    end else begin
      {rtk_q, ltk_q, itk_q} <= 3'h0;
      if (acc_st && !req_q) begin
        req_q <= 1'b1;
        mem_q <= acc;
      end
      if (done) begin
        req_q <= 1'b0;
        dat_q <= mem_rdata;
      end
      case (fsm_q)
        S_IDLE: if (start) begin
          ir_q <= hw;
          op_q <= dec_op;
          busy_q <= 1'b1;
          bad_q <= dec_op == bad_op;
          wr_q <= (dec_op == store_status_op) ? status_q : wp_q;
          sa_q <= wp_q + {11'h000, hw[3:0], 1'b0};
          case (dec_op)
            store_status_op, store_workspace_ptr_op: fsm_q <= S_WREG;
            extended_operation_trap:
              fsm_q <= (hw[5:4] == 2'b00) ? S_VWP : (hw[5:4] == 2'b10) ? S_SIDX : S_SRC;
            workspace_return_op: fsm_q <= S_R14;
            bad_op: fsm_q <= S_END;
            default: fsm_q <= S_IMM;
          endcase
        end else if (idle_wr) begin
          if (ap_addr_q == REG_PC) pc_q <= hw;
          if (ap_addr_q == REG_WP) wp_q <= hw;
          if (ap_addr_q == REG_STAT) status_q <= hw;
        end
        S_IMM: if (done) begin
          imm_q <= mem_rdata;
          pc_q <= pc_q + WORD_INC;
          fsm_q <= (op_q == load_immediate_op || op_q == load_workspace_ptr_op ||
                    op_q == load_int_mask_op) ? S_EXE : S_RREG;
        end
        S_RREG: if (done) fsm_q <= S_EXE;
        S_EXE: begin
          wr_q <= alu_res;
          fsm_q <= S_END;
          case (op_q)
            load_workspace_ptr_op: wp_q <= imm_q;
            load_int_mask_op: status_q[3:0] <= imm_q[3:0];
            compare_immediate_op: status_q <= alu_stat;
            default: begin
              status_q <= alu_stat;
              fsm_q <= S_WREG;
            end
          endcase
        end
        S_WREG: if (done) fsm_q <= S_END;
        S_SIDX: if (done) begin
          sa_q <= mem_rdata;
          pc_q <= pc_q + WORD_INC;
          fsm_q <= (rn == 4'h0) ? S_VWP : S_SRC;
        end
        S_SRC: if (done) begin
          sa_q <= (smode == 2'b10) ? sa_q + mem_rdata : mem_rdata;
          fsm_q <= (smode == 2'b11) ? S_SINC : S_VWP;
        end
        S_SINC: if (done) fsm_q <= S_VWP;
        S_VWP: if (done) begin
          nwp_q <= mem_rdata;
          fsm_q <= S_VPC;
        end
        S_VPC: if (done) begin
          npc_q <= mem_rdata;
          fsm_q <= S_S11;
        end
        S_S11: if (done) fsm_q <= S_S13;
        S_S13: if (done) fsm_q <= S_S14;
        S_S14: if (done) fsm_q <= S_S15;
        S_S15: if (done) begin
          wp_q <= nwp_q;
          pc_q <= npc_q;
          status_q[STAT_TRAP] <= 1'b1;
          fsm_q <= S_END;
        end
        S_R14: if (done) begin
          npc_q <= mem_rdata;
          fsm_q <= S_R13;
        end
        S_R13: if (done) begin
          nwp_q <= mem_rdata;
          fsm_q <= S_R15;
        end
        S_R15: if (done) begin
          status_q <= mem_rdata;
          wp_q <= nwp_q;
          pc_q <= npc_q;
          fsm_q <= S_END;
        end
        S_END: begin
          busy_q <= 1'b0;
          fsm_q <= S_IDLE;
          if (s2_q[2]) rtk_q <= 1'b1;
          else if (s2_q[1]) ltk_q <= 1'b1;
          else if (s2_q[0] && op_q != extended_operation_trap && status_q[3:0] != 4'h0)
            itk_q <= 1'b1;
        end
        default: fsm_q <= S_IDLE;
      endcase
    end
  end

  // outputs straight from flops, except hreadyout and hresp, which are tied to constants
  assign hrdata     = hrdata_q;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign mem_req    = req_q;
  assign mem_out    = mem_q;
  assign busy       = busy_q;
  assign reset_take = rtk_q;
  assign load_take  = ltk_q;
  assign int_take   = itk_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_trap_bit_set: assert property ((fsm_q == S_S15 && done) |=> status_q[STAT_TRAP])
    else $error("trap bit not set");
  chk_vector_addr: assert property ((fsm_q == S_VPC && req_q) |->
    mem_q.addr == VEC_BASE + {10'h000, ir_q[9:6], 2'b00} + VEC_PCOFS)
    else $error("vector address wrong");
  chk_vector_range: assert property ((fsm_q == S_VWP && req_q) |->
    mem_q.addr >= VEC_BASE && mem_q.addr < VEC_LAST && !mem_q.we)
    else $error("vector outside table");
  chk_context_save: assert property ((fsm_q == S_S13 && req_q) |->
    mem_q.we && mem_q.addr == nwp_q + OFS_R13 && mem_q.wdata == wp_q)
    else $error("old pointer save wrong");
  chk_param_addr: assert property ((fsm_q == S_S11 && req_q) |->
    mem_q.we && mem_q.addr == nwp_q + OFS_R11 && mem_q.wdata == sa_q)
    else $error("parameter address save wrong");
  chk_no_int_trap: assert property ((fsm_q == S_END && op_q == extended_operation_trap)
    |=> !itk_q)
    else $error("interrupt taken after trap");
  chk_wp_load: assert property ((fsm_q == S_EXE && op_q == load_workspace_ptr_op) |=>
    $stable(status_q) && wp_q == $past(imm_q))
    else $error("pointer load wrong");
  chk_mask_load: assert property ((fsm_q == S_EXE && op_q == load_int_mask_op) |=>
    status_q[3:0] == $past(imm_q[3:0]) && status_q[15:4] == $past(status_q[15:4]))
    else $error("mask load wrong");
  chk_cmp_nowrite: assert property ((op_q == compare_immediate_op && req_q) |-> !mem_q.we)
    else $error("compare wrote memory");
  chk_return_restore: assert property ((fsm_q == S_R15 && done) |=>
    status_q == $past(mem_rdata) && wp_q == $past(nwp_q) && pc_q == $past(npc_q))
    else $error("return restore wrong");
  cov_trap: cover property (fsm_q == S_S15 && done);
  cov_return: cover property (fsm_q == S_R15 && done);
  cov_add: cover property (fsm_q == S_WREG && op_q == add_immediate_op && done);
endmodule

//--- src/iex_pkg.sv
/*
  package for the immediate-group and trap execution block: register map,
  status bit positions, opcodes, states and the memory request carrier.
  assumes a 16-bit word machine with bit 0 as the most significant bit.
*/
package iex_pkg;
  // ahb register byte offsets
  localparam logic [7:0]  REG_INSTR = 8'h00;
  localparam logic [7:0]  REG_PC    = 8'h04;
  localparam logic [7:0]  REG_WP    = 8'h08;
  localparam logic [7:0]  REG_STAT  = 8'h0c;
  localparam logic [7:0]  REG_INFO  = 8'h10;
  // values after reset
  localparam logic [15:0] RST_PC    = 16'h0000;
  localparam logic [15:0] RST_WP    = 16'h0000;
  localparam logic [15:0] RST_STAT  = 16'h0000;
  // trap vector table and workspace register offsets in bytes
  localparam logic [15:0] VEC_BASE  = 16'h0040;
  localparam logic [15:0] VEC_LAST  = 16'h007e;
  localparam logic [15:0] VEC_PCOFS = 16'h0002;
  localparam logic [15:0] WORD_INC  = 16'h0002;
  localparam logic [15:0] OFS_R11   = 16'h0016;
  localparam logic [15:0] OFS_R13   = 16'h001a;
  localparam logic [15:0] OFS_R14   = 16'h001c;
  localparam logic [15:0] OFS_R15   = 16'h001e;
  // status bit positions (status bit n sits at vector bit 15-n)
  localparam int STAT_LGT  = 15;
  localparam int STAT_AGT  = 14;
  localparam int STAT_EQ   = 13;
  localparam int STAT_C    = 12;
  localparam int STAT_OV   = 11;
  localparam int STAT_TRAP = 9;
  // opcode fields
  localparam logic [5:0]  TRAP_PAT  = 6'h0b;
  localparam logic [10:0] OPC_LOADI = 11'h010;
  localparam logic [10:0] OPC_RET   = 11'h01c;

  typedef enum logic [3:0] {
    load_immediate_op      = 4'h0,
    add_immediate_op       = 4'h1,
    and_immediate_op       = 4'h2,
    or_immediate_op        = 4'h3,
    compare_immediate_op   = 4'h4,
    store_workspace_ptr_op = 4'h5,
    store_status_op        = 4'h6,
    load_workspace_ptr_op  = 4'h7,
    load_int_mask_op       = 4'h8,
    extended_operation_trap = 4'h9,
    workspace_return_op    = 4'ha,
    bad_op                 = 4'hb
  } iex_op_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'h00, S_IMM = 5'h01, S_RREG = 5'h02, S_EXE = 5'h03,
    S_WREG = 5'h04, S_SRC = 5'h05, S_SIDX = 5'h06, S_SINC = 5'h07,
    S_VWP = 5'h08, S_VPC = 5'h09, S_S11 = 5'h0a, S_S13 = 5'h0b,
    S_S14 = 5'h0c, S_S15 = 5'h0d, S_R14 = 5'h0e, S_R13 = 5'h0f,
    S_R15 = 5'h10, S_END = 5'h11
  } iex_state_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } iex_mem_t;
endpackage

//--- verif/iex_mem_model.sv
/*
  word memory model for the far side of the execution block.
  assumes one request at a time; answers after lat idle cycles with a one-cycle ack.
*/
`timescale 1ns/1ns
module iex_mem_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        mem_req,
  input  iex_pkg::iex_mem_t mem_out,
  input  wire logic [1:0]  lat,
  output logic [15:0]      mem_rdata,
  output logic             mem_ack
);
  import iex_pkg::*;
  logic [15:0] mem [0:255];
  logic [1:0]  wait_q;

  // answer each request once; read data toggles when not valid so stale values never pass
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack   <= 1'b0;
      wait_q    <= 2'd0;
      mem_rdata <= 16'h5a5a;
    end else if (mem_ack) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && wait_q == lat) begin
      mem_ack <= 1'b1;
      wait_q  <= 2'd0;
      if (mem_out.we) begin
        mem[mem_out.addr[8:1]] <= mem_out.wdata;
        mem_rdata              <= ~mem_rdata;
      end else begin
        mem_rdata <= mem[mem_out.addr[8:1]];
      end
    end else begin
      wait_q    <= mem_req ? wait_q + 2'd1 : 2'd0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

//--- verif/immediate_and_extended_op_exec_tb_top.sv
/*
  self-checking bench for the immediate-group and trap execution block.
  assumes the memory model above and that hready is the slave's hreadyout.
*/
`timescale 1ns/1ns
module immediate_and_extended_op_exec_tb_top;
  import iex_pkg::*;
  typedef struct packed {
    logic [15:0] ins, opd, pre, reg_e, stat_e, wp_e;
    logic        chk;
  } iex_case_t;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, mem_req, mem_ack, busy;
  logic        reset_request, load_request, maskable_int_request;
  logic        reset_take, load_take, int_take;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, lat;
  logic [2:0]  hsize, tk;
  logic [15:0] mem_rdata;
  logic [3:0]  dn;
  iex_mem_t    mem_out;
  iex_case_t   cases [0:12];
  iex_case_t   c;
  logic [15:0] sa [0:3];
  int          num_errors, comparisons;

  iex_exec iex_exec_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
    .mem_out(mem_out), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .reset_request(reset_request), .load_request(load_request),
    .maskable_int_request(maskable_int_request), .busy(busy), .reset_take(reset_take),
    .load_take(load_take), .int_take(int_take));
  iex_mem_model iex_mem_model_inst (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
    .mem_out(mem_out), .lat(lat), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  // clock generation
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic print_verdict();
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one single ahb-lite transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [15:0] wd,
                     output logic [15:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0000, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[15:0];
  endtask

  task automatic wreg(input logic [7:0] a, input logic [15:0] v);
    logic [15:0] d;
    ahb(1'b1, a, v, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    ahb(1'b0, a, 16'h0000, d);
    chk16(d, e);
  endtask

  // start an instruction, optionally poke pc while busy, wait for the end
  task automatic run(input logic [15:0] ins, input logic junk, output logic [2:0] t);
    int n;
    logic [15:0] d;
    ahb(1'b1, REG_INSTR, ins, d);
    if (junk) ahb(1'b1, REG_PC, 16'hdead, d);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (busy !== 1'b0 && n < 400);
    t = {reset_take, load_take, int_take};
    if (n >= 400) num_errors++;
  endtask

  // watchdog against a hung instruction
  initial begin
    #1000000;
    num_errors++;
    print_verdict();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    reset_request = 1'b0;
    load_request = 1'b0;
    maskable_int_request = 1'b0;
    lat = 2'd0;
    num_errors = 0;
    comparisons = 0;
    for (int i = 0; i < 256; i++) iex_mem_model_inst.mem[i] = 16'h0000;
    sa = '{16'h0108, 16'h0150, 16'h0170, 16'h0150};
    cases = '{
      '{16'h0202, 16'h00ff, 16'h3000, 16'h00ff, 16'hd000, 16'h0100, 1'b1},
      '{16'h0222, 16'hff01, 16'hc80f, 16'h0000, 16'h300f, 16'h0100, 1'b1},
      '{16'h0222, 16'h8000, 16'h000f, 16'h8000, 16'h800f, 16'h0100, 1'b1},
      '{16'h0222, 16'h8000, 16'h0000, 16'h0000, 16'h3800, 16'h0100, 1'b1},
      '{16'h0202, 16'hf0f0, 16'h0000, 16'hf0f0, 16'h8000, 16'h0100, 1'b1},
      '{16'h0242, 16'h0f0f, 16'h1800, 16'h0000, 16'h3800, 16'h0100, 1'b1},
      '{16'h0262, 16'h7001, 16'h0000, 16'h7001, 16'hc000, 16'h0100, 1'b1},
      '{16'h0282, 16'h7001, 16'hc000, 16'h7001, 16'h2000, 16'h0100, 1'b1},
      '{16'h0282, 16'h8000, 16'h0007, 16'h7001, 16'h4007, 16'h0100, 1'b1},
      '{16'h02c3, 16'h0000, 16'habc5, 16'habc5, 16'habc5, 16'h0100, 1'b1},
      '{16'h02a5, 16'h0000, 16'h1234, 16'h0100, 16'h1234, 16'h0100, 1'b1},
      '{16'h0300, 16'hfff5, 16'he000, 16'h0000, 16'he005, 16'h0100, 1'b0},
      '{16'h02e0, 16'h0140, 16'habcd, 16'h0000, 16'habcd, 16'h0140, 1'b0}};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(REG_PC, RST_PC);
    rchk(REG_WP, RST_WP);
    rchk(REG_STAT, RST_STAT);
    wreg(8'h20, 16'hffff);
    rchk(8'h20, 16'h0000);
    maskable_int_request <= 1'b1;
    wreg(REG_WP, 16'h0100);
    // immediate group, one table row per case, memory latency varied
    foreach (cases[i]) begin
      c = cases[i];
      lat <= 2'(i);
      wreg(REG_STAT, c.pre);
      wreg(REG_PC, 16'h00c0);
      iex_mem_model_inst.mem[8'h60] = c.opd;
      run(c.ins, 1'b0, tk);
      if (c.chk) chk16(iex_mem_model_inst.mem[8'h80 + c.ins[3:0]], c.reg_e);
      rchk(REG_STAT, c.stat_e);
      rchk(REG_WP, c.wp_e);
      chk3(tk, {2'b00, c.stat_e[3:0] != 4'h0});
    end
    // trap in all four source modes, numbers 0, 5, 10, 15
    for (int m = 0; m < 4; m++) begin
      dn = 4'(m * 5);
      lat <= 2'(m);
      wreg(REG_WP, 16'h0100);
      wreg(REG_PC, 16'h00c0);
      wreg(REG_STAT, 16'h0005);
      iex_mem_model_inst.mem[8'h60] = 16'h0020;
      iex_mem_model_inst.mem[8'h84] = 16'h0150;
      iex_mem_model_inst.mem[8'h20 + {3'b000, dn, 1'b0}] = 16'h0180;
      iex_mem_model_inst.mem[8'h21 + {3'b000, dn, 1'b0}] = 16'h0a00 + {12'h000, dn};
      run({6'b001011, dn, 2'(m), 4'h4}, 1'b1, tk);
      chk16(iex_mem_model_inst.mem[8'hcb], sa[m]);
      chk16(iex_mem_model_inst.mem[8'hcd], 16'h0100);
      chk16(iex_mem_model_inst.mem[8'hce], (m == 2) ? 16'h00c2 : 16'h00c0);
      chk16(iex_mem_model_inst.mem[8'hcf], 16'h0005);
      rchk(REG_WP, 16'h0180);
      rchk(REG_PC, 16'h0a00 + {12'h000, dn});
      rchk(REG_STAT, 16'h0205);
      chk3(tk, 3'b000);
    end
    chk16(iex_mem_model_inst.mem[8'h84], 16'h0152);
    // return from the last trap
    run(16'h0380, 1'b0, tk);
    rchk(REG_PC, 16'h00c0);
    rchk(REG_WP, 16'h0100);
    rchk(REG_STAT, 16'h0005);
    chk3(tk, 3'b001);
    // load and reset requests win over the maskable request
    @(posedge hclk);
    load_request <= 1'b1;
    run(16'h02a5, 1'b0, tk);
    chk3(tk, 3'b010);
    @(posedge hclk);
    reset_request <= 1'b1;
    run(16'h02a5, 1'b0, tk);
    chk3(tk, 3'b100);
    rchk(REG_INSTR, 16'h02a5);
    // an undefined opcode makes no access, raises the bad flag, and the held reset request is still taken
    run(16'h0000, 1'b0, tk);
    chk3(tk, 3'b100);
    rchk(REG_INFO, 16'h0002);
    print_verdict();
  end
endmodule
